// ### spcu_map.svh
// Register map, field positions, reset values and timing counts
`ifndef SPCU_MAP_SVH
`define SPCU_MAP_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define SPCU_CTRL_IDX 6'h06
`define SPCU_DATA_IDX 6'h07
`define SPCU_MODE_IDX 6'h08
`define SPCU_STAT_IDX 6'h09
`define SPCU_MASK_IDX 6'h0a

// ****************************************
// Reset values and field positions
// ****************************************
`define SPCU_CTRL_RST 8'h00
`define SPCU_MODE_RST 8'h00
`define SPCU_B_RXDONE 0
`define SPCU_B_TXDONE 1
`define SPCU_B_RX9    2
`define SPCU_B_TX9    3
`define SPCU_B_RXEN   4
`define SPCU_B_QUAL   5
`define SPCU_B_MHI    6
`define SPCU_B_MLO    7
`define SPCU_B_FCHK   0
`define SPCU_B_BDBL   1

// ****************************************
// Bit periods in clocks or baud ticks
// ****************************************
`define SPCU_PER_M0_SLOW 7'h0c
`define SPCU_PER_M0_FAST 7'h04
`define SPCU_PER_X16     7'h10
`define SPCU_PER_X32     7'h20
`define SPCU_PER_X64     7'h40

`endif

// ### spcu_pkg.sv
// Types shared by the serial port control unit
package spcu_pkg;
  // Mode number is {mode_select_lo, mode_select_hi}
  typedef enum logic [1:0] {SPCU_M0, SPCU_M1, SPCU_M2, SPCU_M3} spcu_mode_t;
  typedef enum logic {SPCU_TX_IDLE, SPCU_TX_SHIFT} spcu_tx_st_t;
  typedef enum logic [1:0] {SPCU_RX_IDLE, SPCU_RX_START, SPCU_RX_BITS, SPCU_RX_EVAL} spcu_rx_st_t;
  // Read view of the control register
  typedef struct packed {
    logic lo_or_err;
    logic mode_hi;
    logic qual;
    logic rx_en;
    logic tx9;
    logic rx9;
    logic tx_done;
    logic rx_done;
  } spcu_ctrl_t;
endpackage : spcu_pkg

// ### spcu_top.sv
// Serial port control unit with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "spcu_map.svh"

module spcu_top
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  input  wire logic        baud_tick,
  input  wire logic        rxd_i,
  output var  logic        rxd_o,
  output var  logic        rxd_oe_n,
  output var  logic        txd,
  output var  logic        irq
);
  import spcu_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  logic        aw_have_q, w_have_q, lane0_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic        rx_done_q, tx_done_q, rx9_q, tx9_q, rx_en_q, qual_q;
  logic        mode_hi_q, mode_lo_q, frame_err_q, frm_chk_q, bdbl_q;
  logic [7:0]  rx_buf_q;
  logic [2:0]  int_stat_q, int_mask_q;
  spcu_ctrl_t  ctrl_view;

  // Write decode; only byte lane 0 carries register data
  wire       aw_take = s_axi_awvalid & s_axi_awready;
  wire       w_take  = s_axi_wvalid & s_axi_wready;
  wire       ar_take = s_axi_arvalid & s_axi_arready;
  wire       wr_go   = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [5:0] wr_idx  = aw_addr_q[7:2];
  wire       wr_map  = (aw_addr_q[1:0] == 2'h0) & (wr_idx >= `SPCU_CTRL_IDX)
                       & (wr_idx <= `SPCU_MASK_IDX);
  wire       wr_en   = wr_go & wr_map & lane0_q;
  wire       wr_ctrl = wr_en & (wr_idx == `SPCU_CTRL_IDX);
  wire       wr_dat  = wr_en & (wr_idx == `SPCU_DATA_IDX);
  wire       wr_mode = wr_en & (wr_idx == `SPCU_MODE_IDX);
  wire       wr_stat = wr_en & (wr_idx == `SPCU_STAT_IDX);
  wire       wr_mask = wr_en & (wr_idx == `SPCU_MASK_IDX);

  // Read decode; bit 7 shows the error flag while framing check is on
  assign ctrl_view = '{frm_chk_q ? frame_err_q : mode_lo_q, mode_hi_q, qual_q,
                       rx_en_q, tx9_q, rx9_q, tx_done_q, rx_done_q};
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire       rd_map = (s_axi_araddr[1:0] == 2'h0) & (rd_idx >= `SPCU_CTRL_IDX)
                      & (rd_idx <= `SPCU_MASK_IDX);
  wire [7:0] rd_byte = (rd_idx == `SPCU_CTRL_IDX) ? ctrl_view
                     : (rd_idx == `SPCU_DATA_IDX) ? rx_buf_q
                     : (rd_idx == `SPCU_MODE_IDX) ? {6'h00, bdbl_q, frm_chk_q}
                     : (rd_idx == `SPCU_STAT_IDX) ? {5'h00, int_stat_q}
                     : {5'h00, int_mask_q};

  // Write channel: address and data held until both are in
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      lane0_q       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        lane0_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;   // Unmapped: SLVERR
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_map ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      s_axi_rresp   <= rd_map ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Mode and bit timing
  // ****************************************
  spcu_tx_st_t tx_st_q;
  spcu_rx_st_t rx_st_q;
  logic [10:0] tx_sh_q;
  logic [9:0]  rx_sh_q;
  logic [6:0]  tx_cnt_q, rx_cnt_q;
  logic [3:0]  tx_bit_q, rx_bit_q;
  logic        rxd_m_q, rxd_s_q;

  wire spcu_mode_t mode = spcu_mode_t'({mode_lo_q, mode_hi_q});
  wire       m0     = (mode == SPCU_M0);
  wire       m1     = (mode == SPCU_M1);
  // Modes 2 and 3 carry a ninth bit
  wire       m23    = mode_lo_q;
  wire [6:0] bit_per = m0 ? (qual_q ? `SPCU_PER_M0_FAST : `SPCU_PER_M0_SLOW)
                     : !bdbl_q ? `SPCU_PER_X64
                     : (mode == SPCU_M2) ? `SPCU_PER_X32 : `SPCU_PER_X16;
  wire [6:0] half_per = {1'b0, bit_per[6:1]};
  // Modes 1 and 3 run from the baud tick, modes 0 and 2 from the clock
  wire       tick   = (m1 | (mode == SPCU_M3)) ? baud_tick : 1'b1;

  // Two-stage synchroniser on the receive pin
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end
    else
    begin
      rxd_m_q <= rxd_i;
      rxd_s_q <= rxd_m_q;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  wire        tx_busy = (tx_st_q == SPCU_TX_SHIFT);
  wire        rx_busy = (rx_st_q != SPCU_RX_IDLE);
  wire        tx_end  = tx_busy & tick & (tx_cnt_q == bit_per - 7'h01);
  wire [3:0]  tx_last = m0 ? 4'h7 : m1 ? 4'h8 : 4'h9;
  wire [3:0]  tx_stop = m0 ? 4'h7 : m1 ? 4'h9 : 4'ha;
  // Mode 0 is half duplex: a data write during a running reception is dropped
  wire        tx_go   = wr_dat & ~tx_busy & ~(m0 & rx_busy);
  wire        tx_set  = tx_end & (tx_bit_q == tx_last);
  wire [10:0] tx_load = m0 ? {3'h7, w_data_q[7:0]}
                      : m1 ? {2'h3, w_data_q[7:0], 1'b0}
                      : {1'b1, tx9_q, w_data_q[7:0], 1'b0};

  // Shift out LSB first, one bit per period
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_q  <= SPCU_TX_IDLE;
      tx_sh_q  <= 11'h7ff;
      tx_cnt_q <= 7'h00;
      tx_bit_q <= 4'h0;
    end
    else if (tx_go)
    begin
      tx_st_q  <= SPCU_TX_SHIFT;
      tx_sh_q  <= tx_load;
      tx_cnt_q <= 7'h00;
      tx_bit_q <= 4'h0;
    end
    else if (tx_busy & tick)
    begin
      tx_cnt_q <= tx_end ? 7'h00 : tx_cnt_q + 7'h01;
      if (tx_end)
      begin
        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == tx_stop)
          tx_st_q <= SPCU_TX_IDLE;
      end
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  wire       rx_end   = rx_busy & tick & (rx_cnt_q == bit_per - 7'h01);
  wire       rx_half  = (rx_st_q == SPCU_RX_START) & tick & (rx_cnt_q == half_per - 7'h01);
  wire       rx_go_a  = (rx_st_q == SPCU_RX_IDLE) & rx_en_q & ~m0 & ~rxd_s_q;
  wire       rx_go_0  = (rx_st_q == SPCU_RX_IDLE) & rx_en_q & m0 & ~rx_done_q
                        & ~tx_busy & ~tx_go;
  wire [3:0] rx_last  = m0 ? 4'h7 : m1 ? 4'h8 : 4'h9;
  wire       rx_to_ev = rx_end & (rx_st_q == SPCU_RX_BITS)
                        & ((rx_bit_q == rx_last) | (m23 & (rx_bit_q == 4'h8)));
  wire       rx_eval  = (rx_st_q == SPCU_RX_EVAL);
  // First visit judges data and ninth bit; the late visit in modes 2/3 the stop
  wire       ev_data  = rx_eval & (rx_bit_q != 4'ha);
  wire       ev_stop  = rx_eval & (m1 | (rx_bit_q == 4'ha));
  wire       rx_stopb = m23 ? rx_sh_q[9] : rx_sh_q[8];
  // Qualifier wants stop=1 in mode 1 and ninth=1 in modes 2/3, both bit 8
  wire       rx_ok    = m0 | ~qual_q | rx_sh_q[8];
  wire       rx_set   = ev_data & rx_ok;
  wire       fe_set   = ev_stop & frm_chk_q & ~rx_stopb;

  // Sample at mid-bit (async) or at the end of each shift period (mode 0)
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_q  <= SPCU_RX_IDLE;
      rx_sh_q  <= 10'h000;
      rx_cnt_q <= 7'h00;
      rx_bit_q <= 4'h0;
    end
    else
    begin
      if (rx_busy & tick)
        rx_cnt_q <= (rx_end | rx_half) ? 7'h00 : rx_cnt_q + 7'h01;
      unique case (rx_st_q)
        SPCU_RX_IDLE:
        begin
          rx_cnt_q <= 7'h00;
          rx_bit_q <= 4'h0;
          if (rx_go_a)
            rx_st_q <= SPCU_RX_START;
          else if (rx_go_0)
            rx_st_q <= SPCU_RX_BITS;
        end
        SPCU_RX_START:
          if (rx_half)
            rx_st_q <= rxd_s_q ? SPCU_RX_IDLE : SPCU_RX_BITS;  // False start bit
        SPCU_RX_BITS:
          if (rx_end)
          begin
            rx_sh_q[rx_bit_q] <= rxd_s_q;
            rx_bit_q          <= rx_bit_q + 4'h1;
            if (rx_to_ev)
              rx_st_q <= SPCU_RX_EVAL;
          end
        SPCU_RX_EVAL:
          rx_st_q <= (m23 & (rx_bit_q == 4'h9)) ? SPCU_RX_BITS : SPCU_RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Control, mode and interrupt registers
  // ****************************************
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {mode_lo_q, mode_hi_q, qual_q, rx_en_q, tx9_q, rx9_q, tx_done_q, rx_done_q}
        <= `SPCU_CTRL_RST;
      frame_err_q <= 1'b0;
      {bdbl_q, frm_chk_q} <= 2'(`SPCU_MODE_RST);
      rx_buf_q    <= 8'h00;
      int_stat_q  <= 3'h0;
      int_mask_q  <= 3'h0;
    end
    else
    begin
      rx_done_q <= (wr_ctrl ? w_data_q[`SPCU_B_RXDONE] : rx_done_q) | rx_set;
      tx_done_q <= (wr_ctrl ? w_data_q[`SPCU_B_TXDONE] : tx_done_q) | tx_set;
      frame_err_q <= (wr_ctrl & frm_chk_q ? w_data_q[`SPCU_B_MLO] : frame_err_q)
                     | fe_set;
      if (wr_ctrl)
      begin
        tx9_q     <= w_data_q[`SPCU_B_TX9];
        rx_en_q   <= w_data_q[`SPCU_B_RXEN];
        qual_q    <= w_data_q[`SPCU_B_QUAL];
        mode_hi_q <= w_data_q[`SPCU_B_MHI];
        if (!frm_chk_q)
          mode_lo_q <= w_data_q[`SPCU_B_MLO];  // Held while bit 7 is the error flag
      end
      if (rx_set & ~m0)
        rx9_q <= rx_sh_q[8];
      else if (wr_ctrl)
        rx9_q <= w_data_q[`SPCU_B_RX9];
      if (rx_set)
        rx_buf_q <= rx_sh_q[7:0];
      if (wr_mode)
      begin
        frm_chk_q <= w_data_q[`SPCU_B_FCHK];
        bdbl_q    <= w_data_q[`SPCU_B_BDBL];
      end
      int_stat_q <= (int_stat_q & ~(wr_stat ? w_data_q[2:0] : 3'h0))
                    | {fe_set, tx_set, rx_set};
      if (wr_mask)
        int_mask_q <= w_data_q[2:0];
    end
  end

  // ****************************************
  // Pin and interrupt outputs
  // ****************************************
  wire       m0_act = m0 & (tx_busy | rx_busy);
  wire [6:0] clk_cnt = tx_busy ? tx_cnt_q : rx_cnt_q;
  // Mode 0 shift clock is low for the first half of each bit
  wire       txd_d  = m0 ? ~(m0_act & (clk_cnt < half_per))
                         : (tx_busy ? tx_sh_q[0] : 1'b1);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txd      <= 1'b1;
      rxd_o    <= 1'b1;
      rxd_oe_n <= 1'b1;
      irq      <= 1'b0;
    end
    else
    begin
      txd      <= txd_d;
      rxd_o    <= tx_sh_q[0];
      rxd_oe_n <= ~(m0 & tx_busy);
      irq      <= |(int_stat_q & int_mask_q);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_tx_load;
    tx_go & m23;
  endsequence
  sequence s_ninth_out;
    tx_sh_q[9] == $past(tx9_q);
  endsequence

  property p_ctrl_write;
    wr_ctrl |=> (rx_en_q == $past(w_data_q[`SPCU_B_RXEN]))
                && (qual_q == $past(w_data_q[`SPCU_B_QUAL]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost");

  property p_rx_sticky;
    rx_done_q && !wr_ctrl |=> rx_done_q;
  endproperty
  a_rx_sticky: assert property (p_rx_sticky) else $error("rx flag dropped");

  property p_tx_flag;
    tx_set |=> tx_done_q ##0 (int_stat_q[1] || $past(wr_stat));
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("tx flag not set");

  property p_ninth_tx;
    s_tx_load |=> s_ninth_out;
  endproperty
  a_ninth_tx: assert property (p_ninth_tx) else $error("ninth bit wrong");

  property p_mp_block;
    ev_data && m23 && qual_q && !rx_sh_q[8] && !rx_done_q && !wr_ctrl |=> !rx_done_q;
  endproperty
  a_mp_block: assert property (p_mp_block) else $error("mp frame flagged");

  property p_stop_drop;
    ev_data && m1 && qual_q && !rx_sh_q[8] |-> !rx_set;
  endproperty
  a_stop_drop: assert property (p_stop_drop) else $error("bad stop kept");

  property p_rx_off;
    !rx_en_q && !rx_busy |=> !rx_busy;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx ran disabled");

  property p_m0_period;
    tx_busy && $past(tx_busy) && m0 && $stable(mode) && $changed(tx_bit_q)
      |-> $past(tx_cnt_q) == (qual_q ? 7'h03 : 7'h0b);
  endproperty
  a_m0_period: assert property (p_m0_period) else $error("mode 0 period");

  property p_irq;
    |(int_stat_q & int_mask_q) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

endmodule : spcu_top
`default_nettype wire

// ### spcu_peer.sv
// Serial line partner: drives the receive pin and samples the transmit pin
`timescale 1ns/100ps
`default_nettype none

module spcu_peer
(
  input  wire logic clk,
  input  wire logic txd,
  output var  logic line
);
  // Line rests at the marking level between frames, as a real sender leaves it
  initial line = 1'b1;

  // Send n bits LSB first; the last bit may be cut short so a bad stop
  // bit cannot be mistaken for the next start edge
  task automatic send(input logic [10:0] bits, input int n, input int per, input int last);
    for (int i = 0; i < n; i++)
    begin
      line <= bits[i];
      repeat ((i == n - 1) ? last : per) @(posedge clk);
    end
    line <= 1'b1;
  endtask : send

  // Wait for a start edge, then sample every bit in its middle
  task automatic recv(input int n, input int per, output logic [10:0] bits);
    bits = '0;
    while (txd !== 1'b0) @(posedge clk);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = txd;
      repeat (per) @(posedge clk);
    end
  endtask : recv
endmodule : spcu_peer

`default_nettype wire

// ### tb_spcu_top.sv
// Self-checking testbench for the serial port control unit
`timescale 1ns/100ps
`default_nettype none
`include "spcu_map.svh"

module tb_spcu_top;
  localparam logic [5:0] a_ctrl = `SPCU_CTRL_IDX;
  localparam logic [5:0] a_data = `SPCU_DATA_IDX;
  localparam logic [5:0] a_mode = `SPCU_MODE_IDX;
  localparam logic [5:0] a_stat = `SPCU_STAT_IDX;
  localparam logic [5:0] a_mask = `SPCU_MASK_IDX;
  logic        core_clk, rst_n, rxd_o, rxd_oe_n, txd, irq, oe, dbit;
  logic        baud_tick = 1'b0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d, d2;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [10:0] got;
  logic [33:0] exp_q[$];
  logic [1:0]  bexp_q[$];
  wire         peer_line;
  wire         rxd_line;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          seed = 32'he85c9d86;
  int          n;

  // Shared data pin: the block wins while its enable is low
  assign rxd_line = rxd_oe_n ? peer_line : rxd_o;

  spcu_top u_spcu_top
  (
    .core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .baud_tick,
    .rxd_i(rxd_line), .rxd_o, .rxd_oe_n, .txd, .irq
  );

  spcu_peer u_spcu_peer
  (
    .clk(core_clk),
    .txd(txd),
    .line(peer_line)
  );

  // ****************************************
  // Clock, baud ticks and bus helpers
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // One tick every other clock, so 16 ticks span 32 clocks
  always @(posedge core_clk)
    baud_tick <= ~baud_tick;

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Read response and data against the oldest note
  task automatic chk_rd(input logic [33:0] exp, input logic [33:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] read data expected %h seen %h", exp, seen);
    end
  endtask : chk_rd

  // Write response against the oldest note
  task automatic chk_wr(input logic [1:0] exp, input logic [1:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] write response expected %h seen %h", exp, seen);
    end
  endtask : chk_wr

  // Whole serial frame as the partner sampled it
  task automatic chk_frame(input logic [10:0] exp, input logic [10:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] serial frame expected %h seen %h", exp, seen);
    end
  endtask : chk_frame

  task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] resp);
    bexp_q.push_back(resp);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {24'h0, v};
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // Expected read is noted here and judged by the monitor below
  task automatic rd(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] resp);
    exp_q.push_back({resp, 24'h0, v});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  // Monitor takes the oldest note at every read or write handshake
  always @(posedge core_clk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk_rd(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk_wr(bexp_q.pop_front(), s_axi_bresp);
  end

  task automatic rx_frame(input logic [10:0] b, input int nb, input int last);
    u_spcu_peer.send(b, nb, 32, last);
    repeat (4) @(posedge core_clk);
  endtask : rx_frame

  // Length of the first low half of the shift clock, and the pin enable then
  task automatic low_len(output int cnt, output logic en, output logic b0);
    cnt = 0;
    while (txd !== 1'b0) @(posedge core_clk);
    en = rxd_oe_n;
    b0 = rxd_o;
    while (txd === 1'b0)
    begin
      cnt++;
      @(posedge core_clk);
    end
  endtask : low_len

  task automatic complete_run;
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Cut a hang short; the whole run needs well under this span
  initial
  begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(a_ctrl, `SPCU_CTRL_RST, 2'b00);
    rd(a_mode, `SPCU_MODE_RST, 2'b00);
    // Receive enable kept clear so a random mode 0 value starts nothing
    repeat (4)
    begin
      d = 8'($random(seed)) & 8'hef;
      wr(a_ctrl, d, 2'b00);
      rd(a_ctrl, d, 2'b00);
    end
    rd(6'h30, 8'h00, 2'b10);
    wr(6'h30, 8'hff, 2'b10);
    wr(a_stat, 8'h07, 2'b00);
    // Mode 2 at double rate: 32 clocks a bit, ninth bit one
    wr(a_mode, 8'h02, 2'b00);
    wr(a_mask, 8'h02, 2'b00);
    wr(a_ctrl, 8'h88, 2'b00);
    d = 8'($random(seed));
    fork
      wr(a_data, d, 2'b00);
      u_spcu_peer.recv(11, 32, got);
    join
    chk_frame({2'b11, d, 1'b0}, got);
    rd(a_ctrl, 8'h8a, 2'b00);
    chk("irq on transmit", 34'h1, {33'h0, irq});
    wr(a_stat, 8'h02, 2'b00);
    repeat (2) @(posedge core_clk);
    chk("irq after clear", 34'h0, {33'h0, irq});
    // Mode 2 reception, receive status masked at first
    wr(a_ctrl, 8'h90, 2'b00);
    rx_frame({2'b11, d, 1'b0}, 11, 32);
    rd(a_ctrl, 8'h95, 2'b00);
    rd(a_data, d, 2'b00);
    chk("irq masked", 34'h0, {33'h0, irq});
    wr(a_mask, 8'h03, 2'b00);
    repeat (2) @(posedge core_clk);
    chk("irq unmasked", 34'h1, {33'h0, irq});
    wr(a_stat, 8'h07, 2'b00);
    // Multiprocessor: ninth bit zero is ignored, one is taken
    wr(a_ctrl, 8'hb0, 2'b00);
    d2 = 8'($random(seed));
    rx_frame({2'b10, d2, 1'b0}, 11, 32);
    rd(a_ctrl, 8'hb0, 2'b00);
    rd(a_data, d, 2'b00);
    chk("irq stays low", 34'h0, {33'h0, irq});
    rx_frame({2'b11, d2, 1'b0}, 11, 32);
    rd(a_ctrl, 8'hb5, 2'b00);
    rd(a_data, d2, 2'b00);
    wr(a_stat, 8'h07, 2'b00);
    // Receiver switched off
    wr(a_ctrl, 8'h80, 2'b00);
    rx_frame({2'b11, ~d2, 1'b0}, 11, 32);
    rd(a_ctrl, 8'h80, 2'b00);
    rd(a_data, d2, 2'b00);
    // Mode 3 on baud ticks, 16 ticks a bit at double rate
    wr(a_ctrl, 8'hd0, 2'b00);
    rx_frame({2'b11, ~d2, 1'b0}, 11, 32);
    rd(a_ctrl, 8'hd5, 2'b00);
    rd(a_data, ~d2, 2'b00);
    // Mode 1 on baud ticks; bad stop is held only past its middle sample
    wr(a_ctrl, 8'h50, 2'b00);
    rx_frame({2'b01, d, 1'b0}, 10, 32);
    rd(a_ctrl, 8'h55, 2'b00);
    rd(a_data, d, 2'b00);
    wr(a_ctrl, 8'h70, 2'b00);
    rx_frame({2'b00, d2, 1'b0}, 10, 20);
    rd(a_ctrl, 8'h70, 2'b00);
    rd(a_data, d, 2'b00);
    // Framing check on: bad stop kept with qualifier clear, bit 7 flags it
    wr(a_mode, 8'h03, 2'b00);
    wr(a_stat, 8'h07, 2'b00);
    wr(a_ctrl, 8'h54, 2'b00);
    rx_frame({2'b00, d2, 1'b0}, 10, 20);
    rd(a_ctrl, 8'hd1, 2'b00);
    rd(a_stat, 8'h05, 2'b00);
    rd(a_data, d2, 2'b00);
    wr(a_mode, 8'h02, 2'b00);
    // Mode 0 transmit: shift clock low for half a period
    wr(a_ctrl, 8'h00, 2'b00);
    fork
      wr(a_data, d, 2'b00);
      low_len(n, oe, dbit);
    join
    chk("slow shift clock low", 34'd6, 34'(n));
    chk("first data bit slow", {33'h0, d[0]}, {33'h0, dbit});
    chk("data pin driven", 34'h0, {33'h0, oe});
    repeat (150) @(posedge core_clk);
    rd(a_ctrl, 8'h02, 2'b00);
    wr(a_ctrl, 8'h20, 2'b00);
    fork
      wr(a_data, d2, 2'b00);
      low_len(n, oe, dbit);
    join
    chk("fast shift clock low", 34'd2, 34'(n));
    chk("first data bit fast", {33'h0, d2[0]}, {33'h0, dbit});
    repeat (60) @(posedge core_clk);
    rd(a_ctrl, 8'h22, 2'b00);
    chk("data pin released", 34'h1, {33'h0, rxd_oe_n});
    // Mode 0 reception with the data pin held low: eight zero bits
    fork
      wr(a_ctrl, 8'h30, 2'b00);
      u_spcu_peer.send(11'h000, 1, 60, 60);
    join
    rd(a_ctrl, 8'h31, 2'b00);
    rd(a_data, 8'h00, 2'b00);
    complete_run();
  end
endmodule : tb_spcu_top

`default_nettype wire
